// >>> verilog/halt_standby_wake_control.v
// halt and regulator-off standby control with wake-up and AHB-Lite registers
`timescale 1ns/1ps
`include "halt_wake_map.vh"

// Notes on behaviour
// - writing 1 to the halt bit enters halt and stops all clocks except the real-time clock
// - the last internal oscillator edge is used to switch it off
// - halt ends on reset pin or on pin and external line interrupts
// - clocked peripherals never wake; only comparator, real-time clock, pins
// - a source wakes only if enabled and its wake mask bit is set
// - pins wake on low level, on-chip peripheral flags on high level
// - wake restarts the oscillator; cpu resumes on its first edge
// - after wake with global enable set, branch to the waking service routine, then continue
// - hardware clears the halt bit during wake-up
// - in halt every clock stops except the real-time clock
// - halt plus standby bit enters halt with main regulator off
// - standby leaves on the same events and turns the regulator on
// - the oscillator stays enabled in every mode except halt
// - on wake the clock selection is forced to the internal oscillator
// - oscillator defaults to 16 MHz; trim stays within 50 percent
// - no hardware check guards selection of an absent clock
// - after reset the clock selection is the internal oscillator
// - each wake mask bit lets its line wake; mask resets to all ones
// - wake path is separate; disabled interrupt resumes next instruction
module halt_standby_wake_control #(
	parameter LINES = `WAKE_LINES,
	parameter PINS = `PIN_LINES,
	parameter VW = `VEC_W
) (
	input wire sys_clk_in,
	input wire reset_n_in,
	// AHB-Lite slave
	input wire hsel_in,
	input wire [31:0] haddr_in,
	input wire [1:0] htrans_in,
	input wire hwrite_in,
	input wire [2:0] hsize_in,
	input wire [31:0] hwdata_in,
	input wire hready_in,
	output wire [31:0] hrdata_out,
	output wire hreadyout_out,
	output wire hresp_out,
	// core handshake
	input wire cpu_instr_done_in,
	// wake sources
	input wire [PINS-1:0] ext_pin_interrupt_n_in,
	input wire [LINES-PINS-1:0] ext_line_interrupt_in,
	input wire [3:0] clocked_periph_irq_in,
	// oscillator edge strobe, one cycle per internal oscillator edge
	input wire osc_edge_in,
	// clock and power controls
	output wire cpu_clk_en_out,
	output wire periph_clk_en_out,
	output wire rtc_clk_en_out,
	output wire osc_enable_out,
	output wire main_regulator_on_out,
	output wire [1:0] clock_select_out,
	output wire [7:0] osc_trim_out,
	// wake results toward the core
	output wire isr_request_out,
	output wire [VW-1:0] isr_vector_out,
	output wire resume_out
);

////////////////////////////////////////////////////////////////////////////////
// power states
localparam [2:0] ST_RUN = 3'h0;
localparam [2:0] ST_ARM = 3'h1;
localparam [2:0] ST_SHUT = 3'h2;
localparam [2:0] ST_HALT = 3'h3;
localparam [2:0] ST_WAKE = 3'h4;

reg [2:0] state_q;
reg [2:0] state_d;

// software registers
reg halt_q;
reg standby_q;
reg [LINES-1:0] wake_mask_q;
reg [8:0] int_enable_q;
reg [1:0] clock_select_q;
reg [7:0] osc_trim_q;
reg [LINES-1:0] wake_cause_q;

// wake capture and outputs
reg wake_pending_q;
reg [VW-1:0] vector_q;
reg isr_request_q;
reg resume_q;
reg cpu_clk_en_q;
reg periph_clk_en_q;
reg osc_enable_q;
reg regulator_on_q;

// bus state
reg wr_pend_q;
reg [7:0] wr_addr_q;
reg [31:0] hrdata_q;

wire wake_any;
wire [LINES-1:0] wake_hit;
wire [VW-1:0] wake_vector;

////////////////////////////////////////////////////////////////////////////////
// clocked peripherals are not on the wake path at all; their irqs
// go only to the core's interrupt logic, which runs on gated clocks
wire [3:0] clocked_irq_unused = clocked_periph_irq_in;

// wake lines: pins plus comparator and real-time clock style lines
wake_source_filter #(
	.LINES(LINES),
	.PINS(PINS),
	.VW(VW)
) u_filter (
	.pin_n_in(ext_pin_interrupt_n_in),
	.line_in(ext_line_interrupt_in),
	.mask_in(wake_mask_q),
	.enable_in(int_enable_q[LINES-1:0]),
	.wake_any_out(wake_any),
	.wake_hit_out(wake_hit),
	.wake_vector_out(wake_vector)
);

////////////////////////////////////////////////////////////////////////////////
// bus decode: a transfer is taken in its address phase
wire bus_take = hsel_in & htrans_in[1] & hready_in;
wire bus_wr = bus_take & hwrite_in;
wire bus_rd = bus_take & ~hwrite_in;
wire [7:0] bus_ofs = haddr_in[7:0];
wire hsize_unused = |hsize_in;

// write strobes, valid during the data phase
function wr_hit;
	input [7:0] ofs;
	input pend;
	input [7:0] addr;
	begin
		wr_hit = pend & (addr == ofs);
	end
endfunction

wire wr_pwr = wr_hit(`OFS_POWER_CONTROL, wr_pend_q, wr_addr_q);
wire wr_mask = wr_hit(`OFS_WAKE_MASK, wr_pend_q, wr_addr_q);
wire wr_inten = wr_hit(`OFS_INT_ENABLE, wr_pend_q, wr_addr_q);
wire wr_clksel = wr_hit(`OFS_CLOCK_SELECT, wr_pend_q, wr_addr_q);
wire wr_trim = wr_hit(`OFS_OSC_TRIM, wr_pend_q, wr_addr_q);
wire wr_cause = wr_hit(`OFS_WAKE_CAUSE, wr_pend_q, wr_addr_q);

// trim writes outside the window are clamped, keeping flash timing safe
wire [7:0] trim_in = hwdata_in[7:0];
wire [7:0] trim_clamped = (trim_in < `TRIM_MIN) ? `TRIM_MIN :
	(trim_in > `TRIM_MAX) ? `TRIM_MAX : trim_in;

// status word assembled from live state
wire [31:0] status_word = {25'h0, cpu_clk_en_q, osc_enable_q,
	regulator_on_q, 1'b0, state_q};

// read mux, unmapped offsets read as zero
reg [31:0] rd_mux;
always @* begin
	rd_mux = 32'h00000000;
	case (bus_ofs)
		`OFS_POWER_CONTROL: rd_mux[1:0] = {standby_q, halt_q};
		`OFS_WAKE_MASK: rd_mux[LINES-1:0] = wake_mask_q;
		`OFS_INT_ENABLE: rd_mux[8:0] = int_enable_q;
		`OFS_CLOCK_SELECT: rd_mux[1:0] = clock_select_q;
		`OFS_OSC_TRIM: rd_mux[7:0] = osc_trim_q;
		`OFS_STATUS: rd_mux = status_word;
		`OFS_WAKE_CAUSE: rd_mux[LINES-1:0] = wake_cause_q;
		default: rd_mux = 32'h00000000;
	endcase
end

// address phase capture; read data is registered for the data phase
always @(posedge sys_clk_in or negedge reset_n_in) begin
	if (!reset_n_in) begin
		wr_pend_q <= 1'b0;
		wr_addr_q <= 8'h00;
		hrdata_q <= 32'h00000000;
	end else begin
		wr_pend_q <= bus_wr;
		if (bus_wr) begin
			wr_addr_q <= bus_ofs;
		end
		if (bus_rd) begin
			hrdata_q <= rd_mux;
		end
	end
end

// zero wait states, always OKAY
assign hreadyout_out = 1'b1;
assign hresp_out = 1'b0;
assign hrdata_out = hrdata_q;

////////////////////////////////////////////////////////////////////////////////
// state sequencing
wire wake_now = wake_any | wake_pending_q;

always @* begin
	state_d = state_q;
	case (state_q)
		ST_RUN: begin
			if (halt_q) begin
				state_d = ST_ARM;
			end
		end
		ST_ARM: begin
			// the writing instruction must retire first
			if (cpu_instr_done_in) begin
				state_d = ST_SHUT;
			end
		end
		ST_SHUT: begin
			// oscillator is stopped on its own last edge
			if (osc_edge_in) begin
				state_d = wake_now ? ST_WAKE : ST_HALT;
			end
		end
		ST_HALT: begin
			if (wake_any) begin
				state_d = ST_WAKE;
			end
		end
		ST_WAKE: begin
			// cpu restarts on first edge of the restarted oscillator
			if (osc_edge_in) begin
				state_d = ST_RUN;
			end
		end
		default: state_d = ST_RUN;
	endcase
end

// wake that lands during shutdown is remembered, never dropped
always @(posedge sys_clk_in or negedge reset_n_in) begin
	if (!reset_n_in) begin
		wake_pending_q <= 1'b0;
		vector_q <= {VW{1'b0}};
	end else begin
		if ((state_q == ST_SHUT) && wake_any && !wake_pending_q) begin
			wake_pending_q <= 1'b1;
			vector_q <= wake_vector;
		end else if ((state_q == ST_HALT) && wake_any) begin
			vector_q <= wake_vector;
		end else if (state_q == ST_RUN) begin
			wake_pending_q <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// state register and clock, oscillator, regulator controls
wire leaving = (state_q == ST_WAKE) && osc_edge_in;
wire quiet = (state_d == ST_SHUT) || (state_d == ST_HALT) ||
	(state_d == ST_WAKE);

always @(posedge sys_clk_in or negedge reset_n_in) begin
	if (!reset_n_in) begin
		state_q <= ST_RUN;
		cpu_clk_en_q <= 1'b1;
		periph_clk_en_q <= 1'b1;
		osc_enable_q <= 1'b1;
		regulator_on_q <= 1'b1;
		isr_request_q <= 1'b0;
		resume_q <= 1'b0;
	end else begin
		state_q <= state_d;
		// no core or peripheral clock from shutdown until resume
		cpu_clk_en_q <= ~quiet;
		periph_clk_en_q <= ~quiet;
		// oscillator off only while truly halted
		osc_enable_q <= (state_d != ST_HALT);
		// regulator drops only in halt with standby set
		regulator_on_q <= ~((state_d == ST_HALT) & standby_q);
		// with global enable, branch to the routine; else next instruction
		isr_request_q <= leaving & int_enable_q[`INTEN_GLOBAL_BIT];
		resume_q <= leaving & ~int_enable_q[`INTEN_GLOBAL_BIT];
	end
end

////////////////////////////////////////////////////////////////////////////////
// software registers
always @(posedge sys_clk_in or negedge reset_n_in) begin
	if (!reset_n_in) begin
		halt_q <= 1'b0;
		standby_q <= 1'b0;
		wake_mask_q <= `RST_WAKE_MASK;
		int_enable_q <= `RST_INT_ENABLE;
		clock_select_q <= `RST_CLOCK_SELECT;
		osc_trim_q <= `RST_OSC_TRIM;
	end else begin
		if (leaving) begin
			// wake clears the mode bits and returns to internal oscillator
			halt_q <= 1'b0;
			standby_q <= 1'b0;
			clock_select_q <= `CLKSEL_INTERNAL;
		end else if (wr_pwr && (state_q == ST_RUN)) begin
			halt_q <= hwdata_in[`PWR_HALT_BIT];
			standby_q <= hwdata_in[`PWR_STANDBY_BIT];
		end else if (wr_clksel) begin
			// any code is accepted; an absent source can hang the system
			clock_select_q <= hwdata_in[1:0];
		end
		if (wr_mask) begin
			wake_mask_q <= hwdata_in[LINES-1:0];
		end
		if (wr_inten) begin
			int_enable_q <= hwdata_in[8:0];
		end
		if (wr_trim) begin
			osc_trim_q <= trim_clamped;
		end
	end
end

// sticky wake cause, write one to clear; a new hit wins over the clear
always @(posedge sys_clk_in or negedge reset_n_in) begin
	if (!reset_n_in) begin
		wake_cause_q <= {LINES{1'b0}};
	end else begin
		wake_cause_q <= (wake_cause_q &
			~(wr_cause ? hwdata_in[LINES-1:0] : {LINES{1'b0}})) |
			((state_q == ST_HALT || state_q == ST_SHUT) ?
			wake_hit : {LINES{1'b0}});
	end
end

////////////////////////////////////////////////////////////////////////////////
// outputs
assign cpu_clk_en_out = cpu_clk_en_q;
assign periph_clk_en_out = periph_clk_en_q;
assign rtc_clk_en_out = 1'b1;
assign osc_enable_out = osc_enable_q;
assign main_regulator_on_out = regulator_on_q;
assign clock_select_out = clock_select_q;
assign osc_trim_out = osc_trim_q;
assign isr_request_out = isr_request_q;
assign isr_vector_out = vector_q;
assign resume_out = resume_q;

endmodule

// >>> include/halt_wake_map.vh
// register map, field positions, reset values and counts for halt/wake control
`ifndef HALT_WAKE_MAP_VH
`define HALT_WAKE_MAP_VH

// register byte offsets on the AHB-Lite slave
`define OFS_POWER_CONTROL 8'h00
`define OFS_WAKE_MASK 8'h04
`define OFS_INT_ENABLE 8'h08
`define OFS_CLOCK_SELECT 8'h0c
`define OFS_OSC_TRIM 8'h10
`define OFS_STATUS 8'h14
`define OFS_WAKE_CAUSE 8'h18

// power_control_reg fields
`define PWR_HALT_BIT 0
`define PWR_STANDBY_BIT 1

// interrupt_enable_reg: per-line enables in [7:0], global enable here
`define INTEN_GLOBAL_BIT 8

// status register fields
`define STAT_STATE_LSB 0
`define STAT_REG_ON_BIT 4
`define STAT_OSC_ON_BIT 5
`define STAT_CPU_RUN_BIT 6

// reset values
`define RST_WAKE_MASK 8'hff
`define RST_INT_ENABLE 9'h000
`define RST_CLOCK_SELECT 2'h0
`define RST_OSC_TRIM 8'h80

// clock selection code of the internal oscillator
`define CLKSEL_INTERNAL 2'h0

// trim window: 16 MHz centre code, limited to +/-50 percent of it
`define TRIM_MIN 8'h40
`define TRIM_MAX 8'hc0

// number of wake lines and width of the vector number
`define WAKE_LINES 8
`define PIN_LINES 2
`define VEC_W 3

`endif

// >>> verilog/wake_source_filter.v
// wake-line polarity, qualification and priority pick
`timescale 1ns/1ps

module wake_source_filter #(
	parameter LINES = 8,
	parameter PINS = 2,
	parameter VW = 3
) (
	input wire [PINS-1:0] pin_n_in,
	input wire [LINES-PINS-1:0] line_in,
	input wire [LINES-1:0] mask_in,
	input wire [LINES-1:0] enable_in,
	output wire wake_any_out,
	output wire [LINES-1:0] wake_hit_out,
	output wire [VW-1:0] wake_vector_out
);

////////////////////////////////////////////////////////////////////////////////
// lowest line number wins when several lines wake together
function [VW-1:0] first_set;
	input [LINES-1:0] bits;
	integer i;
	begin
		first_set = {VW{1'b0}};
		for (i = LINES - 1; i >= 0; i = i - 1) begin
			if (bits[i]) begin
				first_set = i[VW-1:0];
			end
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// pins wake on low level, on-chip flags on high level
wire [LINES-1:0] level_active;
genvar g;
generate
	for (g = 0; g < LINES; g = g + 1) begin : g_pol
		if (g < PINS) begin : g_pin
			assign level_active[g] = ~pin_n_in[g];
		end else begin : g_line
			assign level_active[g] = line_in[g-PINS];
		end
	end
endgenerate

// a line wakes only if enabled and unmasked
assign wake_hit_out = level_active & mask_in & enable_in;
assign wake_any_out = |wake_hit_out;
assign wake_vector_out = first_set(wake_hit_out);

endmodule

// >>> test/halt_wake_monitor.sv
// port assertions for the halt and standby control
`timescale 1ns/1ps
`include "halt_wake_map.vh"
module halt_wake_monitor (
	input wire sys_clk_in,
	input wire reset_n_in,
	input wire cpu_instr_done_in,
	input wire osc_edge_in,
	input wire cpu_clk_en_out,
	input wire periph_clk_en_out,
	input wire rtc_clk_en_out,
	input wire osc_enable_out,
	input wire main_regulator_on_out,
	input wire [1:0] clock_select_out,
	input wire isr_request_out,
	input wire resume_out
);
	// one domain, so clock and reset are given once
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	clk_stop_a: assert property (
		$fell(cpu_clk_en_out) |-> $past(cpu_instr_done_in) && !periph_clk_en_out)
		else $error("clocks stopped before the write retired");
	rtc_run_a: assert property (rtc_clk_en_out)
		else $error("real-time clock enable dropped");
	osc_last_a: assert property (
		$fell(osc_enable_out) |-> $past(osc_edge_in) && !cpu_clk_en_out)
		else $error("oscillator stopped off its last edge");
	osc_mode_a: assert property (
		!osc_enable_out |-> !cpu_clk_en_out && !periph_clk_en_out)
		else $error("oscillator off while clocks run");
	resume_edge_a: assert property (
		$rose(cpu_clk_en_out) |-> $past(osc_edge_in) && osc_enable_out)
		else $error("cpu resumed off an oscillator edge");
	wake_branch_a: assert property (
		$rose(cpu_clk_en_out) |-> isr_request_out != resume_out)
		else $error("wake gave no single branch or resume");
	sel_internal_a: assert property (
		$rose(cpu_clk_en_out) |-> clock_select_out == `CLKSEL_INTERNAL)
		else $error("clock selection not internal after wake");
	wake_pulse_a: assert property (
		isr_request_out || resume_out |=> !isr_request_out && !resume_out)
		else $error("wake pulse longer than one cycle");
	reg_off_a: assert property (
		!main_regulator_on_out |-> !osc_enable_out && !cpu_clk_en_out)
		else $error("regulator off outside halt");
	reg_back_a: assert property (
		$rose(osc_enable_out) |-> main_regulator_on_out ##[1:8] cpu_clk_en_out)
		else $error("wake did not restore regulator and clocks");
endmodule
////////////////////////////////////////
bind halt_standby_wake_control halt_wake_monitor mon_u (
	.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
	.cpu_instr_done_in(cpu_instr_done_in), .osc_edge_in(osc_edge_in),
	.cpu_clk_en_out(cpu_clk_en_out), .periph_clk_en_out(periph_clk_en_out),
	.rtc_clk_en_out(rtc_clk_en_out), .osc_enable_out(osc_enable_out),
	.main_regulator_on_out(main_regulator_on_out),
	.clock_select_out(clock_select_out), .isr_request_out(isr_request_out),
	.resume_out(resume_out));

// >>> test/osc_core_model.sv
// oscillator and core model facing the halt control
`timescale 1ns/1ps
module osc_core_model (
	input wire sys_clk_in,
	input wire reset_n_in,
	input wire osc_enable_in,
	input wire cpu_clk_en_in,
	output wire osc_edge_out,
	output wire instr_done_out
);
	logic [1:0] div_q;
	// free divider; the oscillator is slower than the bus clock
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div_q <= 2'h0;
		end else begin
			div_q <= div_q + 2'h1;
		end
	end
	// no edges while disabled; core retires only while its clock runs
	assign osc_edge_out = osc_enable_in & (div_q == 2'h3);
	assign instr_done_out = cpu_clk_en_in & div_q[0];
endmodule

// >>> test/tb_halt_standby_wake_control.sv
// self-checking bench for the halt and standby control
`timescale 1ns/1ps
`include "halt_wake_map.vh"
module tb_halt_standby_wake_control;
	typedef struct packed {logic [1:0] pin_n; logic [5:0] line;
		logic [3:0] pirq; logic [7:0] mask; logic [8:0] ien; logic stby;
		logic early; logic x_isr; logic x_res; logic [2:0] x_vec;} row_t;
	logic sys_clk_in, reset_n_in, hsel, hwrite, got_i, got_r;
	logic [31:0] haddr, hwdata, rd;
	logic [1:0] htrans, pin_n;
	logic [5:0] line;
	logic [3:0] pirq;
	logic [2:0] got_v;
	wire [31:0] hrdata;
	wire hready, hresp, cpu_clk_en, periph_clk_en, rtc_en, osc_en, reg_on;
	wire isr, resume, osc_edge, done;
	wire [1:0] csel;
	wire [7:0] trim;
	wire [2:0] vec;
	int n_errors, n_compared, cyc, n;
	// regulator settle idle after a standby wake: 20 us of 5 ns cycles
	localparam int SETTLE_CYC = 4000;
	row_t rows [8];
	row_t r;
	halt_standby_wake_control dut_u (.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
		.hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp), .cpu_instr_done_in(done),
		.ext_pin_interrupt_n_in(pin_n), .ext_line_interrupt_in(line),
		.clocked_periph_irq_in(pirq), .osc_edge_in(osc_edge),
		.cpu_clk_en_out(cpu_clk_en), .periph_clk_en_out(periph_clk_en),
		.rtc_clk_en_out(rtc_en), .osc_enable_out(osc_en),
		.main_regulator_on_out(reg_on), .clock_select_out(csel),
		.osc_trim_out(trim), .isr_request_out(isr), .isr_vector_out(vec),
		.resume_out(resume));
	osc_core_model part_u (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
		.osc_enable_in(osc_en), .cpu_clk_en_in(cpu_clk_en),
		.osc_edge_out(osc_edge), .instr_done_out(done));
	////////////////////////////////////////
	// single AHB-Lite transfer, waits on hready in both phases
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge sys_clk_in); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk_in); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic do_reset;
		reset_n_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		reset_n_in <= 1'b1;
	endtask
	task automatic stop_test;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// clock, and a ceiling well above the expected run of about 5000 cycles
	initial begin
		sys_clk_in = 1'b0;
		forever #2.5 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 10000) begin
			n_errors++;
			stop_test();
		end
	end
	// wake rows: pins, lines, clocked irqs, mask, enables, standby, early
	initial begin
		rows[0] = '{2'h2, 6'h00, 4'h0, 8'hff, 9'h1ff, 0, 0, 1, 0, 3'h0};
		rows[1] = '{2'h1, 6'h00, 4'h0, 8'hff, 9'h0ff, 0, 0, 0, 1, 3'h0};
		rows[2] = '{2'h3, 6'h01, 4'h0, 8'hff, 9'h1ff, 1, 0, 1, 0, 3'h2};
		rows[3] = '{2'h3, 6'h20, 4'h0, 8'h7f, 9'h1ff, 0, 0, 0, 0, 3'h0};
		rows[4] = '{2'h3, 6'h20, 4'h0, 8'hff, 9'h17f, 0, 0, 0, 0, 3'h0};
		rows[5] = '{2'h3, 6'h00, 4'hf, 8'hff, 9'h1ff, 0, 0, 0, 0, 3'h0};
		rows[6] = '{2'h2, 6'h08, 4'h0, 8'hff, 9'h1ff, 0, 1, 1, 0, 3'h0};
		rows[7] = '{2'h1, 6'h00, 4'h0, 8'hfd, 9'h1ff, 0, 0, 0, 0, 3'h0};
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		{pin_n, line, pirq} = {2'h3, 6'h00, 4'h0};
		reset_n_in = 1'b0;
		do_reset();
		ahb(0, `OFS_WAKE_MASK, 0);
		check(rd, 32'hff);
		ahb(0, `OFS_CLOCK_SELECT, 0);
		check(rd, 32'h0);
		ahb(0, `OFS_OSC_TRIM, 0);
		check(rd, 32'h80);
		ahb(0, 8'h1c, 0);
		check(rd, 32'h0);
		ahb(1, `OFS_OSC_TRIM, 32'hff);
		// the write lands on the edge the task returns at; look one later
		@(posedge sys_clk_in);
		check(32'(trim), 32'hc0);
		ahb(0, `OFS_OSC_TRIM, 0);
		check(rd, 32'hc0);
		ahb(0, `OFS_STATUS, 0);
		check(rd, 32'h70);
		check(32'(hresp), 32'h0);
		$display("register test done");
		for (int k = 0; k < 8; k++) begin
			r = rows[k];
			do_reset();
			ahb(1, `OFS_WAKE_MASK, {24'h0, r.mask});
			ahb(1, `OFS_INT_ENABLE, {23'h0, r.ien});
			// odd rows go back to the internal oscillator before halt; even
			// rows keep a settled foreign source to see the forced return
			ahb(1, `OFS_CLOCK_SELECT, k[0] ? 32'h0 : 32'h3);
			ahb(1, `OFS_POWER_CONTROL, {30'h0, r.stby, 1'b1});
			if (!r.early) begin
				n = 0;
				while (osc_en !== 1'b0 && n < 100) begin
					@(posedge sys_clk_in);
					n++;
				end
				check(32'(cpu_clk_en), 32'h0);
				check(32'(reg_on), 32'(!r.stby));
			end
			pin_n <= r.pin_n;
			line <= r.line;
			pirq <= r.pirq;
			{got_i, got_r, got_v} = '0;
			repeat (40) begin
				@(posedge sys_clk_in);
				if (isr === 1'b1) {got_i, got_v} = {1'b1, vec};
				if (resume === 1'b1) got_r = 1'b1;
			end
			check(32'(got_i), 32'(r.x_isr));
			check(32'(got_r), 32'(r.x_res));
			check(32'(got_v), 32'(r.x_vec));
			pin_n <= 2'h3;
			line <= 6'h00;
			pirq <= 4'h0;
			if (r.x_isr | r.x_res) begin
				check(32'(csel), 32'(`CLKSEL_INTERNAL));
				check(32'(reg_on), 32'h1);
				// software idles while the main regulator settles
				if (r.stby) repeat (SETTLE_CYC) @(posedge sys_clk_in);
				ahb(0, `OFS_POWER_CONTROL, 0);
				check(rd, 32'h0);
				ahb(0, `OFS_WAKE_CAUSE, 0);
				check(rd, {24'h0, {r.line, ~r.pin_n} & r.mask & r.ien[7:0]});
				ahb(1, `OFS_WAKE_CAUSE, 32'hff);
				ahb(0, `OFS_WAKE_CAUSE, 0);
				check(rd, 32'h0);
			end
			$display("wake row %0d done", k);
		end
		// the last row leaves the device halted; the reset pin ends it
		check(32'(osc_en), 32'h0);
		// halted, regulator on, oscillator and cpu clock off
		ahb(0, `OFS_STATUS, 0);
		check(rd, 32'h13);
		// a power control write outside run is refused
		ahb(1, `OFS_POWER_CONTROL, 0);
		ahb(0, `OFS_POWER_CONTROL, 0);
		check(rd, 32'h1);
		do_reset();
		@(posedge sys_clk_in);
		check(32'({cpu_clk_en, osc_en}), 32'h3);
		$display("reset exit test done");
		stop_test();
	end
endmodule
